// *** inc/tsr_pkg.sv ***
// constants for the tuner serial register bank
package tsr_pkg;
  localparam logic [3:0] REG_DIVIDER_HIGH = 4'h2;
  localparam logic [3:0] REG_DIVIDER_LOW = 4'h3;
  localparam logic [3:0] REG_GAIN_BYPASS_CONTROL = 4'h4;
  localparam logic [3:0] REG_PORT_PUMP_REFDIV = 4'h5;
  localparam logic [3:0] REG_FILTER_SWITCH_CONTROL = 4'h6;
  localparam logic [3:0] REG_PORT_BANDWIDTH = 4'h7;
  localparam logic [3:0] REG_CONTROL_DATA_A = 4'h8;
  localparam logic [3:0] REG_CONTROL_DATA_B = 4'h9;
  localparam logic [3:0] REG_CONTROL_DATA_C = 4'ha;
  localparam logic [3:0] REG_CONTROL_DATA_D = 4'hb;
  localparam logic [3:0] REG_TEST_CONTROL = 4'hc;
  localparam logic [3:0] REG_POWER_FILTER_REF_CONTROL = 4'hd;
  localparam logic [3:0] REG_FIRST = 4'h2;
  localparam logic [3:0] REG_LAST = 4'hd;
  localparam int NUM_REGS = 12;
  // power-on values, index 0 is register 2
  localparam logic [7:0] RST_DIVIDER_HIGH = 8'h00;
  localparam logic [7:0] RST_DIVIDER_LOW = 8'h00;
  localparam logic [7:0] RST_GAIN_BYPASS_CONTROL = 8'h80;
  localparam logic [7:0] RST_PORT_PUMP_REFDIV = 8'h00;
  localparam logic [7:0] RST_FILTER_SWITCH_CONTROL = 8'hc0;
  localparam logic [7:0] RST_PORT_BANDWIDTH = 8'h20;
  localparam logic [7:0] RST_CONTROL_DATA_A = 8'hdb;
  localparam logic [7:0] RST_CONTROL_DATA_B = 8'h30;
  localparam logic [7:0] RST_CONTROL_DATA_C = 8'he1;
  localparam logic [7:0] RST_CONTROL_DATA_D = 8'h75;
  localparam logic [7:0] RST_TEST_CONTROL = 8'hf0;
  localparam logic [7:0] RST_POWER_FILTER_REF_CONTROL = 8'h28;
  // fixed bit patterns
  localparam logic [7:0] DIV_HIGH_MASK = 8'h7f;
  localparam logic [7:0] GAIN_FIXED_MASK = 8'h3f;
  localparam logic [7:0] GAIN_FIXED_VAL = 8'h80;
  localparam logic [7:0] FSW_MASK = 8'h08;
  localparam logic [7:0] FSW_FIXED_VAL = 8'hc0;
  localparam logic [7:0] BW_MASK = 8'hfe;
  // field positions
  localparam int POS_STATUS_POR = 7;
  localparam int POS_STATUS_LOCK = 6;
  localparam int POS_PORT_CTRL = 7;
  localparam int POS_POWER_DOWN = 7;
  localparam int POS_LOGIC_RESET = 1;
  localparam int POS_LO_SELECT = 0;
  localparam int POS_RF_GAIN = 5;
  localparam int POS_BYPASS_DIS = 0;
  localparam int POS_RSW_OFF = 3;
  // device address: 1100_0 sel_hi sel_lo r/w
  localparam logic [4:0] DEV_ADDR_PREFIX = 5'h18;
endpackage : tsr_pkg

// *** core/tsr_serial_register_bank.sv ***
// serial slave register bank of the tuner, status read and twelve control registers
//
// Operation
// [RULE_01] read bit one: act as slave transmitter and send status byte
// [RULE_02] resend status while master acks; release data line on first nack
// [RULE_03] master ends a read with nack then stop
// [RULE_04] status sent msb first: power-on flag bit 7, lock bit 6
// [RULE_05] power-on reset sets power-on flag and restores all registers
// [RULE_06] stop ending a read transaction clears the power-on flag
// [RULE_07] status bit 6 follows synthesizer lock
// [RULE_08] read bit zero: receive bytes, ack address and each data byte
// [RULE_09] master may stop or continue after any acked data byte
// [RULE_10] twelve registers 2..13; bytes after register 13 are discarded
// [RULE_11] first byte upper bits pick even start register; all bits load
// [RULE_12] odd register reachable only after its even partner
// [RULE_13] register pairs may be written in any order across transactions
// [RULE_14] register 2 bit 7 fixed zero; registers 2 and 3 reset zero
// [RULE_15] register 4 fixed 10 in bits 7:6, resets 0x80
// [RULE_16] register 5 port, pump, reference divider fields, resets zero
// [RULE_17] register 6 fixed bits, resistor switch off in bit 3, resets 0xc0
// [RULE_18] register 7 port, bandwidth, bit 0 zero, resets 0x20
// [RULE_19] register 13 power down, filter divider, logic reset, lo select
// [RULE_20] registers 8..12 reset 0xdb 0x30 0xe1 0x75/0xf5 0xf0
// [RULE_21] register 11 bit 7 undefined after power-up
// [RULE_22] software should load recommended values, not rely on defaults
// [RULE_23] logic reset bit restores registers 7, 9..13 then self-clears
// [RULE_24] nack on status byte acts as internal stop, no more reading
// [RULE_25] lock flag also drives the lock output pin
// [RULE_26] powered down when sleep pin or power-down bit is one
// [RULE_27] write pointer advances after each acked data byte
`timescale 1ns/1ps
`default_nettype none
module tsr_serial_register_bank
  import tsr_pkg::*;
#(
  parameter logic [7:0] UNDEF_BIT_RESET = 8'h00
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic addr_sel_hi_i,
  input wire logic addr_sel_lo_i,
  input wire logic pll_lock_i,
  input wire logic sleep_i,
  output logic lock_o,
  output logic power_down_o,
  output logic port_a_ctrl_o,
  output logic port_b_ctrl_o,
  output logic [14:0] divider_ratio_o,
  output logic rf_gain_bit_o,
  output logic [1:0] prefilter_gain_o,
  output logic [1:0] postfilter_gain_o,
  output logic bypass_disable_o,
  output logic [1:0] pump_current_sel_o,
  output logic [4:0] ref_divider_sel_o,
  output logic resistor_switch_off_o,
  output logic [5:0] filter_bandwidth_value_o,
  output logic [4:0] filter_ref_divider_o,
  output logic lo_output_select_o,
  output logic [7:0] control_data_a_o,
  output logic [7:0] control_data_b_o,
  output logic [7:0] control_data_c_o,
  output logic [7:0] control_data_d_o,
  output logic [7:0] test_control_o
);
  // only the undefined bit 7 of register 11 may be chosen, so 0x75 or 0xf5
  if ((UNDEF_BIT_RESET & 8'h7f) != 8'h00) begin : g_bad_undef
    $error("tsr_serial_register_bank: bad UNDEF_BIT_RESET");
  end

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] lock_sync_reg;
  logic [1:0] sleep_sync_reg;
  logic [1:0] addr_hi_sync_reg;
  logic [1:0] addr_lo_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      lock_sync_reg <= 2'h0;
      sleep_sync_reg <= 2'h0;
      addr_hi_sync_reg <= 2'h0;
      addr_lo_sync_reg <= 2'h0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      lock_sync_reg <= {lock_sync_reg[0], pll_lock_i};
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_i};
      addr_hi_sync_reg <= {addr_hi_sync_reg[0], addr_sel_hi_i};
      addr_lo_sync_reg <= {addr_lo_sync_reg[0], addr_sel_lo_i};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // ----------------------------------------------------------------
  // transfer state machine
  // ----------------------------------------------------------------
  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } tsr_state_t;
  tsr_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic is_read_reg;
  logic drive_low_reg;
  logic read_done_reg;
  logic first_byte_reg;
  logic byte_full_reg;
  logic [3:0] wr_ptr_reg;
  logic wr_stb;
  logic [3:0] wr_idx;
  logic [7:0] status_byte;
  logic por_flag_reg;

  // start register from the upper nibble of the first data byte
  function automatic logic [3:0] start_reg(input logic [3:0] hi);
    if (!hi[3]) begin
      start_reg = REG_DIVIDER_HIGH;
    end else if (!hi[2]) begin
      start_reg = REG_GAIN_BYPASS_CONTROL;
    end else begin
      start_reg = REG_FILTER_SWITCH_CONTROL + {1'b0, hi[1:0], 1'b0};
    end
  endfunction

  assign status_byte = {por_flag_reg, lock_sync_reg[1], 6'h00}; // [RULE_04] [RULE_07]
  // at the eighth rise the first seven bits still sit in shift_reg[6:0]
  assign wr_idx = first_byte_reg ? start_reg(shift_reg[6:3]) : wr_ptr_reg; // [RULE_11]
  // register write happens when the eighth bit of a data byte is sampled
  assign wr_stb = (state_reg == ST_WDATA) && scl_rise && (bit_cnt_reg == 3'h7)
    && (wr_idx <= REG_LAST); // [RULE_10]

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      is_read_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      byte_full_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 3'h0;
      drive_low_reg <= 1'b0;
      byte_full_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      drive_low_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          drive_low_reg <= 1'b0;
        end
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            byte_full_reg <= (bit_cnt_reg == 3'h7);
          end
          // a flag marks a whole byte: stale shift contents or 0x00 data must not steer the ack
          if (scl_fall && byte_full_reg) begin
            byte_full_reg <= 1'b0;
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == {DEV_ADDR_PREFIX, addr_hi_sync_reg[1], addr_lo_sync_reg[1]}) begin
                state_reg <= ST_ADDR_ACK;
                is_read_reg <= shift_reg[0]; // [RULE_01] [RULE_08]
                drive_low_reg <= 1'b1; // [RULE_08]
              end else begin
                state_reg <= ST_IDLE;
              end
            end else begin
              state_reg <= ST_WACK;
              drive_low_reg <= 1'b1; // [RULE_08]
            end
          end
        end
        ST_ADDR_ACK, ST_WACK: begin
          if (scl_fall) begin
            shift_reg <= status_byte;
            bit_cnt_reg <= 3'h0;
            if (is_read_reg) begin
              state_reg <= ST_RDATA; // [RULE_01]
              drive_low_reg <= !status_byte[7]; // [RULE_04]
            end else begin
              state_reg <= ST_WDATA;
              shift_reg <= 8'h00;
              drive_low_reg <= 1'b0;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              state_reg <= ST_RACK;
              drive_low_reg <= 1'b0;
            end else begin
              drive_low_reg <= !shift_reg[3'h6 - bit_cnt_reg]; // [RULE_04]
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_reg <= ST_IDLE; // [RULE_24]
            end else begin
              shift_reg <= status_byte; // [RULE_02]
            end
          end
          if (scl_fall) begin
            state_reg <= ST_RDATA;
            bit_cnt_reg <= 3'h0;
            drive_low_reg <= !shift_reg[7]; // [RULE_02]
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // write pointer and read-transaction tracking
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= REG_FIRST;
      first_byte_reg <= 1'b0;
    end else if (state_reg == ST_ADDR_ACK) begin
      first_byte_reg <= 1'b1; // [RULE_13]
    end else if (wr_stb || (state_reg == ST_WDATA && scl_rise && bit_cnt_reg == 3'h7)) begin
      first_byte_reg <= 1'b0;
      wr_ptr_reg <= (wr_idx > REG_LAST) ? wr_idx : wr_idx + 4'h1; // [RULE_27] [RULE_10]
    end
  end

  // a read ended by a stop on the bus; the internal stop after a nack does not count
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_done_reg <= 1'b0;
    end else if (state_reg == ST_ADDR_ACK && is_read_reg) begin
      read_done_reg <= 1'b1;
    end else if (stop_det || start_det) begin
      read_done_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      por_flag_reg <= 1'b1; // [RULE_05]
    end else if (stop_det && read_done_reg) begin
      por_flag_reg <= 1'b0; // [RULE_06]
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // register 11 bit 7 has no defined power-on value; a parameter picks it
  localparam logic [7:0] RESET_VALS [NUM_REGS] = '{
    RST_DIVIDER_HIGH, RST_DIVIDER_LOW, RST_GAIN_BYPASS_CONTROL,
    RST_PORT_PUMP_REFDIV, RST_FILTER_SWITCH_CONTROL, RST_PORT_BANDWIDTH,
    RST_CONTROL_DATA_A, RST_CONTROL_DATA_B, RST_CONTROL_DATA_C,
    RST_CONTROL_DATA_D, RST_TEST_CONTROL, RST_POWER_FILTER_REF_CONTROL}; // [RULE_14] [RULE_15] [RULE_16] [RULE_17] [RULE_18] [RULE_19] [RULE_20]
  logic [7:0] regs_reg [NUM_REGS];
  logic logic_reset;
  assign logic_reset = regs_reg[REG_POWER_FILTER_REF_CONTROL - REG_FIRST][POS_LOGIC_RESET];

  // fixed bits are forced on write so they always read their pattern
  function automatic logic [7:0] fix_bits(input logic [3:0] idx, input logic [7:0] d);
    unique case (idx)
      REG_DIVIDER_HIGH: fix_bits = d & DIV_HIGH_MASK; // [RULE_14]
      REG_GAIN_BYPASS_CONTROL: fix_bits = (d & GAIN_FIXED_MASK) | GAIN_FIXED_VAL; // [RULE_15]
      REG_FILTER_SWITCH_CONTROL: fix_bits = (d & FSW_MASK) | FSW_FIXED_VAL; // [RULE_17]
      REG_PORT_BANDWIDTH: fix_bits = d & BW_MASK; // [RULE_18]
      default: fix_bits = d;
    endcase
  endfunction

  // registers restored by the self-clearing logic reset
  function automatic logic clr_hit(input logic [3:0] idx);
    clr_hit = (idx == REG_PORT_BANDWIDTH) || (idx >= REG_CONTROL_DATA_B); // [RULE_23]
  endfunction

  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      localparam logic [3:0] IDX = REG_FIRST + 4'(g);
      localparam logic [7:0] RV = (IDX == REG_CONTROL_DATA_D) ? UNDEF_BIT_RESET | RESET_VALS[g]
        : RESET_VALS[g]; // [RULE_21]
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          regs_reg[g] <= RV; // [RULE_05]
        end else if (logic_reset && clr_hit(IDX)) begin
          regs_reg[g] <= RV; // [RULE_23]
        end else if (wr_stb && wr_idx == IDX) begin
          regs_reg[g] <= fix_bits(IDX, {shift_reg[6:0], sda_s}); // [RULE_11]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_oe_n_o <= 1'b1;
      lock_o <= 1'b0;
      power_down_o <= 1'b0;
    end else begin
      sda_oe_n_o <= !drive_low_reg; // [RULE_02]
      lock_o <= lock_sync_reg[1]; // [RULE_25]
      power_down_o <= sleep_sync_reg[1]
        || regs_reg[REG_POWER_FILTER_REF_CONTROL - REG_FIRST][POS_POWER_DOWN]; // [RULE_26]
    end
  end
  assign sda_o = 1'b0;
  assign divider_ratio_o = {regs_reg[0][6:0], regs_reg[1]};
  assign rf_gain_bit_o = regs_reg[2][POS_RF_GAIN];
  assign prefilter_gain_o = regs_reg[2][4:3];
  assign postfilter_gain_o = regs_reg[2][2:1];
  assign bypass_disable_o = regs_reg[2][POS_BYPASS_DIS];
  assign port_a_ctrl_o = regs_reg[3][POS_PORT_CTRL];
  assign pump_current_sel_o = regs_reg[3][6:5];
  assign ref_divider_sel_o = regs_reg[3][4:0];
  assign resistor_switch_off_o = regs_reg[4][POS_RSW_OFF];
  assign port_b_ctrl_o = regs_reg[5][POS_PORT_CTRL];
  assign filter_bandwidth_value_o = regs_reg[5][6:1];
  assign control_data_a_o = regs_reg[6];
  assign control_data_b_o = regs_reg[7];
  assign control_data_c_o = regs_reg[8];
  assign control_data_d_o = regs_reg[9];
  assign test_control_o = regs_reg[10];
  assign filter_ref_divider_o = regs_reg[11][6:2];
  assign lo_output_select_o = regs_reg[11][POS_LO_SELECT];
endmodule : tsr_serial_register_bank
`default_nettype wire

// *** verif/tsr_props.sv ***
// assertion checker on the ports of the tuner serial register bank
`timescale 1ns/1ps
`default_nettype none
module tsr_props
  import tsr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic pll_lock_i,
  input wire logic sleep_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic lock_o,
  input wire logic power_down_o,
  input wire logic port_a_ctrl_o,
  input wire logic port_b_ctrl_o,
  input wire logic [14:0] divider_ratio_o,
  input wire logic [5:0] filter_bandwidth_value_o,
  input wire logic [4:0] filter_ref_divider_o,
  input wire logic lo_output_select_o,
  input wire logic [7:0] control_data_a_o,
  input wire logic [7:0] control_data_b_o,
  input wire logic [7:0] control_data_c_o,
  input wire logic [7:0] test_control_o
);
  // ----------------------------------------
  // properties; lock and sleep inputs get six cycles, scl four, to pass the sync flops
  // ----------------------------------------
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  property p_sda_low_only;
    sda_o == 1'b0;
  endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("sda data level not low");
  // bus drive may only move while scl is low
  property p_drive_stands;
    scl_i [*4] |-> $stable(sda_oe_n_o);
  endproperty
  a_drive_stands: assert property (p_drive_stands) else $error("sda drive moved with scl high");
  property p_lock_hi;
    pll_lock_i [*6] |=> lock_o;
  endproperty
  a_lock_hi: assert property (p_lock_hi) else $error("lock pin not high while locked");
  property p_lock_lo;
    !pll_lock_i [*6] |=> !lock_o;
  endproperty
  a_lock_lo: assert property (p_lock_lo) else $error("lock pin not low while unlocked");
  property p_sleep_pd;
    sleep_i [*6] |=> power_down_o;
  endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("sleep pin did not power down");
  property p_rst_ctrl;
    $fell(rst_i) |-> control_data_a_o == RST_CONTROL_DATA_A && control_data_b_o == RST_CONTROL_DATA_B
      && control_data_c_o == RST_CONTROL_DATA_C && test_control_o == RST_TEST_CONTROL;
  endproperty
  a_rst_ctrl: assert property (p_rst_ctrl) else $error("control data not at power-on values");
  property p_rst_synth;
    $fell(rst_i) |-> divider_ratio_o == 15'h0000 && !port_a_ctrl_o && !port_b_ctrl_o
      && filter_bandwidth_value_o == 6'h10;
  endproperty
  a_rst_synth: assert property (p_rst_synth) else $error("divider or bandwidth not at power-on");
  property p_rst_filter;
    $fell(rst_i) |-> filter_ref_divider_o == 5'h0a && !lo_output_select_o && !power_down_o
      && sda_oe_n_o && !lock_o;
  endproperty
  a_rst_filter: assert property (p_rst_filter) else $error("filter divider not at power-on");
endmodule // tsr_props
bind tsr_serial_register_bank tsr_props u_props (
  .sys_clk_i, .rst_i, .scl_i, .pll_lock_i, .sleep_i, .sda_o, .sda_oe_n_o, .lock_o, .power_down_o,
  .port_a_ctrl_o, .port_b_ctrl_o, .divider_ratio_o, .filter_bandwidth_value_o, .filter_ref_divider_o,
  .lo_output_select_o, .control_data_a_o, .control_data_b_o, .control_data_c_o, .test_control_o
);
`default_nettype wire

// *** verif/tsr_bus_master.sv ***
// serial bus master model facing the register bank
`timescale 1ns/1ps
`default_nettype none
module tsr_bus_master (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ----------------------------------------
  // bus phases, a quarter of a 125 ns scl period each; scl idles high
  // ----------------------------------------
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic qtr();
    #31.25;
  endtask
  task automatic start();
    @(posedge clk_i);
    #1;
    sda_low_o = 1'b1;
    qtr();
    scl_o = 1'b0;
    qtr();
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_low_o = 1'b0;
    qtr();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = ~b;
    qtr();
    scl_o = 1'b1;
    qtr();
    r = sda_i;
    qtr();
    scl_o = 1'b0;
    qtr();
  endtask
  // eight bits msb first, then the ninth clock; ack_in one withholds the ack
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask
endmodule // tsr_bus_master
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the tuner serial register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tsr_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic sys_clk_i, rst_i, scl_i, sda_low, addr_sel_hi_i, addr_sel_lo_i, pll_lock_i, sleep_i;
  logic sda_o, sda_oe_n_o, lock_o, power_down_o, port_a_ctrl_o, port_b_ctrl_o, rf_gain_bit_o;
  logic bypass_disable_o, resistor_switch_off_o, lo_output_select_o;
  logic [14:0] divider_ratio_o;
  logic [1:0] prefilter_gain_o, postfilter_gain_o, pump_current_sel_o;
  logic [4:0] ref_divider_sel_o, filter_ref_divider_o;
  logic [5:0] filter_bandwidth_value_o;
  logic [7:0] control_data_a_o, control_data_b_o, control_data_c_o, control_data_d_o, test_control_o;
  logic [7:0] e [2:13];
  int err_total = 0;
  int samples_checked = 0;
  // open-drain line with pull-up
  wire logic sda_i = ~sda_low & (sda_oe_n_o | sda_o);
  tsr_serial_register_bank dut (.sys_clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o, .addr_sel_hi_i,
    .addr_sel_lo_i, .pll_lock_i, .sleep_i, .lock_o, .power_down_o, .port_a_ctrl_o, .port_b_ctrl_o,
    .divider_ratio_o, .rf_gain_bit_o, .prefilter_gain_o, .postfilter_gain_o, .bypass_disable_o,
    .pump_current_sel_o, .ref_divider_sel_o, .resistor_switch_off_o, .filter_bandwidth_value_o,
    .filter_ref_divider_o, .lo_output_select_o, .control_data_a_o, .control_data_b_o,
    .control_data_c_o, .control_data_d_o, .test_control_o);
  tsr_bus_master m (.clk_i(sys_clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_low_o(sda_low));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] por(input int n);
    logic [7:0] t [2:13];
    t = '{RST_DIVIDER_HIGH, RST_DIVIDER_LOW, RST_GAIN_BYPASS_CONTROL, RST_PORT_PUMP_REFDIV,
      RST_FILTER_SWITCH_CONTROL, RST_PORT_BANDWIDTH, RST_CONTROL_DATA_A, RST_CONTROL_DATA_B,
      RST_CONTROL_DATA_C, RST_CONTROL_DATA_D, RST_TEST_CONTROL, RST_POWER_FILTER_REF_CONTROL};
    return t[n];
  endfunction
  // register image rebuilt from the field pins; needs sleep low for register 13
  function automatic logic [7:0] got(input int n);
    case (n)
      2: return {1'b0, divider_ratio_o[14:8]};
      3: return divider_ratio_o[7:0];
      4: return {2'b10, rf_gain_bit_o, prefilter_gain_o, postfilter_gain_o, bypass_disable_o};
      5: return {port_a_ctrl_o, pump_current_sel_o, ref_divider_sel_o};
      6: return {4'hc, resistor_switch_off_o, 3'h0};
      7: return {port_b_ctrl_o, filter_bandwidth_value_o, 1'b0};
      8: return control_data_a_o;
      9: return control_data_b_o;
      10: return control_data_c_o;
      11: return control_data_d_o;
      12: return test_control_o;
      default: return {power_down_o, filter_ref_divider_o, 1'b0, lo_output_select_o};
    endcase
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
    samples_checked++;
    if (g !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic done(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, err_total);
  endtask
  task automatic put(input int p, input logic [7:0] d);
    case (p)
      2: e[p] = d & DIV_HIGH_MASK;
      4: e[p] = (d & GAIN_FIXED_MASK) | GAIN_FIXED_VAL;
      6: e[p] = (d & FSW_MASK) | FSW_FIXED_VAL;
      7: e[p] = d & BW_MASK;
      13: e[p] = d & 8'hfd;
      default: e[p] = d;
    endcase
    if (p == 13 && d[POS_LOGIC_RESET]) begin
      e[7] = por(7);
      for (int k = 9; k <= 13; k++) e[k] = por(k);
    end
  endtask
  task automatic wr(input logic [7:0] q[$]);
    int p;
    logic [7:0] rx;
    logic a;
    m.start();
    m.xfer({DEV_ADDR_PREFIX, addr_sel_hi_i, addr_sel_lo_i, 1'b0}, 1'b1, rx, a);
    chk("write address ack", 8'h00, {7'h00, a});
    p = q[0][7] ? (q[0][6] ? 6 + 2 * q[0][5:4] : 4) : 2;
    foreach (q[i]) begin
      m.xfer(q[i], 1'b1, rx, a);
      chk("data ack", 8'h00, {7'h00, a});
      if (p <= 13) put(p, q[i]);
      p++;
    end
    m.stop();
    cyc(8);
    for (int n = 2; n <= 13; n++) chk($sformatf("register %0d", n), e[n], got(n));
  endtask
  task automatic rd(input int cnt, input logic [7:0] ex);
    logic [7:0] rx;
    logic a;
    m.start();
    m.xfer({DEV_ADDR_PREFIX, addr_sel_hi_i, addr_sel_lo_i, 1'b1}, 1'b1, rx, a);
    chk("read address ack", 8'h00, {7'h00, a});
    for (int i = 1; i <= cnt; i++) begin
      m.xfer(8'hff, i == cnt, rx, a);
      chk("status byte", ex, rx & 8'hc0);
    end
    m.xfer(8'hff, 1'b1, rx, a);
    chk("line after nack", 8'hff, rx);
    m.stop();
    cyc(2);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_por();
    for (int n = 2; n <= 13; n++) chk("power-on register", por(n), got(n));
    rd(3, 8'h80);
    rd(1, 8'h00);
    pll_lock_i = 1'b1;
    cyc(8);
    chk("lock pin high", 8'h01, {7'h00, lock_o});
    rd(2, 8'h40);
    pll_lock_i = 1'b0;
    cyc(8);
    chk("lock pin low", 8'h00, {7'h00, lock_o});
    done("power-on and status");
  endtask
  task automatic t_write();
    // one extra byte past register 13 must vanish
    wr('{8'h12, 8'h34, 8'h55, 8'haa, 8'hff, 8'hff, 8'h11, 8'h22, 8'h33, 8'h44, 8'h66, 8'hfc, 8'h99});
    done("full write");
  endtask
  task automatic t_pairs();
    logic [7:0] fb [6] = '{8'hf3, 8'he5, 8'hd7, 8'hc9, 8'hab, 8'h1c};
    foreach (fb[i]) wr('{fb[i], 8'h5c});
    done("pair select");
  endtask
  task automatic t_clr();
    wr('{8'hf7, 8'h03});
    done("logic reset");
  endtask
  task automatic t_addr();
    logic [7:0] rx;
    logic a;
    addr_sel_hi_i = 1'b1;
    cyc(4);
    m.start();
    m.xfer(8'hc0, 1'b1, rx, a);
    chk("foreign address nack", 8'h01, {7'h00, a});
    m.stop();
    wr('{8'h21, 8'h43});
    done("address select");
  endtask
  task automatic t_sleep();
    sleep_i = 1'b1;
    cyc(8);
    chk("sleep power down", 8'h01, {7'h00, power_down_o});
    sleep_i = 1'b0;
    cyc(8);
    chk("power down bit only", {7'h00, e[13][7]}, {7'h00, power_down_o});
    done("sleep");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    rst_i = 1'b1;
    addr_sel_hi_i = 1'b0;
    addr_sel_lo_i = 1'b0;
    pll_lock_i = 1'b0;
    sleep_i = 1'b0;
    for (int n = 2; n <= 13; n++) e[n] = por(n);
    cyc(8);
    rst_i = 1'b0;
    cyc(4);
    t_por();
    t_write();
    t_pairs();
    t_clr();
    t_addr();
    t_sleep();
    finish_test();
  end
  // 13 transactions of at most about 16 microseconds each
  initial begin
    #400000;
    err_total++;
    $display("MISMATCH watchdog expected finish seen timeout");
    finish_test();
  end
endmodule // tb
`default_nettype wire
